// >>> verilog/sef_map.vh
// constants for the serial memory front end: opcodes, status layout, counts
`ifndef SEF_MAP_VH
`define SEF_MAP_VH

// ------------------------------------------------------------------
// instruction codes the front end recognises
// ------------------------------------------------------------------
`define SEF_OP_WRSR        8'h01
`define SEF_OP_WRITE       8'h02
`define SEF_OP_READ        8'h03
`define SEF_OP_WRDI        8'h04
`define SEF_OP_RDSR        8'h05
`define SEF_OP_WREN        8'h06

// ------------------------------------------------------------------
// status byte layout and reset values
// ------------------------------------------------------------------
`define SEF_ST_WEL_BIT     1
`define SEF_ST_PLO_BIT     2
`define SEF_ST_PHI_BIT     3
`define SEF_PROT_RST       1'h0
`define SEF_WEL_RST        1'h0

// ------------------------------------------------------------------
// framing counts
// ------------------------------------------------------------------
`define SEF_ADDR_BYTES     4'h3
`define SEF_LAST_BIT       3'h7
`define SEF_FIFO_WIDTH     8
`define SEF_FIFO_DEPTH     16

`endif

// >>> verilog/sef_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sef_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // honest flags from the fill count
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage, no reset needed on the array
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // sef_fifo

`default_nettype wire

// >>> verilog/sef_front_end.v
// serial memory front end: spi target pins, command framing, protect bits
// Behaviour
// - serial output changes only on falling serial clock edges.
// - serial input captured on every rising clock edge while selected, not paused and not in standby.
// - incoming instruction, address and data bytes arrive msb first.
// - returned bytes leave msb first.
// - first input bit taken on first rising edge after select falls.
// - read output starts on first falling edge after last status opcode bit or last read address bit.
// - deselected means output in high impedance.
// - no instruction accepted before a select falling edge after power-up.
// - select low makes the device selected and active.
// - pause input suspends the transfer without deselecting; it resumes after.
// - during pause output is high impedance, clock and input ignored.
// - write-protect low freezes the two protect size bits.
// - invalid command gives standby, output off, until next select fall.
// - valid command gives active state until next select rise.
// - clock modes 0 and 3 work; sample rising, drive falling.
`include "sef_map.vh"
`timescale 1ns/1ps
`default_nettype none

module sef_front_end #(
  parameter FIFO_WIDTH = `SEF_FIFO_WIDTH,
  parameter FIFO_DEPTH = `SEF_FIFO_DEPTH
) (
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  input  wire       sel_n_i,
  input  wire       sclk_i,
  input  wire       sdi_i,
  input  wire       pause_n_i,
  input  wire       wp_n_i,
  output reg        sdo_o,
  output reg        sdo_oe_n_o,
  input  wire [7:0] tx_data_i,
  output reg        tx_next_o,
  output reg  [7:0] rx_data_o,
  output reg        rx_valid_o,
  input  wire       rx_ready_i,
  output reg        rx_full_o,
  output reg        rx_drop_o,
  output reg        cmd_start_o,
  output reg  [7:0] cmd_code_o,
  output reg        active_o,
  output reg        protect_size_bit_hi_o,
  output reg        protect_size_bit_lo_o
);

  // ------------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------------
  localparam ST_IDLE    = 2'h0;
  localparam ST_OPCODE  = 2'h1;
  localparam ST_ACTIVE  = 2'h2;
  localparam ST_STANDBY = 2'h3;

  // ------------------------------------------------------------------
  // pin synchronisers: two flops per pin, nothing reads stage one
  // ------------------------------------------------------------------
  wire [4:0] pin_raw;
  reg  [4:0] pin_s1_q;
  reg  [4:0] pin_s2_q;
  assign pin_raw = {wp_n_i, pause_n_i, sdi_i, sclk_i, sel_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      // pause and protect rest high; select rests low in reset so that a
      // select already held low at release never looks like a falling edge
      always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
          pin_s1_q[gi] <= (gi == 3 || gi == 4) ? 1'b1 : 1'b0;
          pin_s2_q[gi] <= (gi == 3 || gi == 4) ? 1'b1 : 1'b0;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  wire sel_n_s  = pin_s2_q[0];
  wire sclk_s   = pin_s2_q[1];
  wire sdi_s    = pin_s2_q[2];
  wire pause_s  = ~pin_s2_q[3];
  wire wp_n_s   = pin_s2_q[4];

  // ------------------------------------------------------------------
  // edge detection on the synchronised pins
  // ------------------------------------------------------------------
  reg  sclk_prev_q;
  reg  sel_prev_q;
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q  <= sel_n_s;
    end
  end

  // a fall needs a high select seen since reset, so power-up stays quiet
  wire sel_fall = sel_prev_q & ~sel_n_s;
  wire selected = ~sel_n_s;
  // pause freezes the shifters; edges seen while paused are dropped
  wire live     = selected & ~pause_s;
  wire sck_rise = live & ~sclk_prev_q & sclk_s;
  wire sck_fall = live & sclk_prev_q & ~sclk_s;

  // ------------------------------------------------------------------
  // framing registers
  // ------------------------------------------------------------------
  reg  [1:0] state_q;
  reg  [2:0] bit_q;
  reg  [7:0] in_sr_q;
  reg  [3:0] byte_q;
  reg  [7:0] op_q;
  reg        out_en_q;
  reg  [7:0] out_sr_q;
  reg  [2:0] out_bit_q;
  reg        wel_q;

  // byte assembled this cycle, msb arrived first
  wire [7:0] in_byte  = {in_sr_q[6:0], sdi_s};
  wire       byte_end = sck_rise & (bit_q == `SEF_LAST_BIT);

  // ------------------------------------------------------------------
  // opcode classification
  // ------------------------------------------------------------------
  wire op_known = (in_byte == `SEF_OP_WRSR)  | (in_byte == `SEF_OP_WRITE) |
                  (in_byte == `SEF_OP_READ)  | (in_byte == `SEF_OP_WRDI)  |
                  (in_byte == `SEF_OP_RDSR)  | (in_byte == `SEF_OP_WREN);

  wire [7:0] status_byte;
  assign status_byte = {4'h0, protect_size_bit_hi_o, protect_size_bit_lo_o, wel_q, 1'b0};

  // ------------------------------------------------------------------
  // receive fifo: address and write data bytes after the opcode
  // ------------------------------------------------------------------
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  wire       fifo_pop = rx_valid_o & rx_ready_i;
  wire       push_req = byte_end & (state_q == ST_ACTIVE) &
                        ((op_q == `SEF_OP_WRITE) | (op_q == `SEF_OP_READ) | (op_q == `SEF_OP_WRSR));

  sef_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_data_i   (in_byte),
    .in_valid_i  (push_req),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (~rx_valid_o | rx_ready_i)
  );

  // output stage: one registered slot in front of the consumer
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_full_o  <= 1'b0;
      rx_drop_o  <= 1'b0;
    end else begin
      if (fifo_out_valid && (!rx_valid_o || rx_ready_i)) begin
        rx_data_o  <= fifo_out_data;
        rx_valid_o <= 1'b1;
      end else if (fifo_pop) begin
        rx_valid_o <= 1'b0;
      end
      rx_full_o <= ~fifo_in_ready;
      // the master cannot be stalled, so a full fifo loses the byte
      rx_drop_o <= push_req & ~fifo_in_ready;
    end
  end

  // ------------------------------------------------------------------
  // command framing state machine
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_q     <= ST_IDLE;
      bit_q       <= 3'h0;
      in_sr_q     <= 8'h00;
      byte_q      <= 4'h0;
      op_q        <= 8'h00;
      cmd_start_o <= 1'b0;
      cmd_code_o  <= 8'h00;
      active_o    <= 1'b0;
    end else begin
      cmd_start_o <= 1'b0;
      if (sel_n_s) begin
        // deselect drops any partial byte and ends the command
        state_q  <= ST_IDLE;
        bit_q    <= 3'h0;
        byte_q   <= 4'h0;
        active_o <= 1'b0;
      end else if (sel_fall) begin
        state_q  <= ST_OPCODE;
        bit_q    <= 3'h0;
        byte_q   <= 4'h0;
        active_o <= 1'b1;
      end else if (sck_rise && (state_q == ST_OPCODE || state_q == ST_ACTIVE)) begin
        in_sr_q <= in_byte;
        bit_q   <= bit_q + 3'h1;
        if (byte_end) begin
          if (state_q == ST_OPCODE) begin
            op_q       <= in_byte;
            cmd_code_o <= in_byte;
            if (op_known) begin
              state_q     <= ST_ACTIVE;
              cmd_start_o <= 1'b1;
            end else begin
              state_q  <= ST_STANDBY;
              active_o <= 1'b0;
            end
          end else if (byte_q != 4'hF) begin
            byte_q <= byte_q + 4'h1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // write enable latch and protect size bits
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wel_q                 <= `SEF_WEL_RST;
      protect_size_bit_hi_o <= `SEF_PROT_RST;
      protect_size_bit_lo_o <= `SEF_PROT_RST;
    end else if (byte_end) begin
      if (state_q == ST_OPCODE && in_byte == `SEF_OP_WREN) begin
        wel_q <= 1'b1;
      end else if (state_q == ST_OPCODE && in_byte == `SEF_OP_WRDI) begin
        wel_q <= 1'b0;
      end else if (state_q == ST_ACTIVE && op_q == `SEF_OP_WRSR && byte_q == 4'h0) begin
        // protect low freezes the area size, the write still ends wel
        if (wp_n_s && wel_q) begin
          protect_size_bit_hi_o <= in_byte[`SEF_ST_PHI_BIT];
          protect_size_bit_lo_o <= in_byte[`SEF_ST_PLO_BIT];
        end
        wel_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // transmit shifter: loads on the rising edge that ends the
  // status opcode or the last read address byte, shifts on every following falling edge
  // ------------------------------------------------------------------
  wire rd_status = byte_end & (state_q == ST_OPCODE) & (in_byte == `SEF_OP_RDSR);
  wire rd_array  = byte_end & (state_q == ST_ACTIVE) & (op_q == `SEF_OP_READ) &
                   (byte_q == `SEF_ADDR_BYTES - 4'h1);

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      out_en_q   <= 1'b0;
      out_sr_q   <= 8'h00;
      out_bit_q  <= 3'h0;
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
      tx_next_o  <= 1'b0;
    end else begin
      tx_next_o <= 1'b0;
      if (!selected || state_q == ST_STANDBY) begin
        out_en_q <= 1'b0;
      end else if (rd_status || rd_array) begin
        out_en_q  <= 1'b1;
        out_sr_q  <= rd_status ? status_byte : tx_data_i;
        out_bit_q <= 3'h0;
        tx_next_o <= rd_array;
      end else if (sck_fall && out_en_q) begin
        sdo_o     <= out_sr_q[7];
        out_bit_q <= out_bit_q + 3'h1;
        if (out_bit_q == `SEF_LAST_BIT) begin
          // status repeats, array data streams from the user side
          out_sr_q  <= (op_q == `SEF_OP_RDSR) ? status_byte : tx_data_i;
          tx_next_o <= (op_q == `SEF_OP_READ);
        end else begin
          out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
      end
      // drive only while selected, reading, and not paused
      sdo_oe_n_o <= ~(selected & ~pause_s & out_en_q &
                      (state_q == ST_ACTIVE));
    end
  end

endmodule // sef_front_end

`default_nettype wire

// >>> tb/sef_chk_properties.sv
// checker for the serial memory front end ports
`timescale 1ns/1ps
`default_nettype none
module sef_chk (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       sel_n_i,
  input wire logic       sclk_i,
  input wire logic       pause_n_i,
  input wire logic       wp_n_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_n_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_ready_i,
  input wire logic       rx_drop_o,
  input wire logic       cmd_start_o,
  input wire logic [7:0] cmd_code_o,
  input wire logic       active_o,
  input wire logic       protect_size_bit_hi_o,
  input wire logic       protect_size_bit_lo_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] fall_age_q;
  logic       sclk_q;
  // cycles since the last serial clock fall; saturates so idle time cannot wrap
  always @(posedge clk_sys_i) begin
    sclk_q <= sclk_i;
    if (!nrst_i) fall_age_q <= 4'hF;
    else if (sclk_q && !sclk_i) fall_age_q <= 4'h0;
    else if (fall_age_q != 4'hF) fall_age_q <= fall_age_q + 4'h1;
  end
  chk_hiz_deselect: assert property (sel_n_i [*6] |-> sdo_oe_n_o)
    else $error("output driven while deselected");
  chk_out_on_fall: assert property (!sdo_oe_n_o && $changed(sdo_o) |-> fall_age_q inside {[4'h1:4'h5]})
    else $error("output moved away from a clock fall");
  chk_hiz_pause: assert property (!pause_n_i [*5] |-> sdo_oe_n_o)
    else $error("output driven while paused");
  chk_idle_quiet: assert property (sel_n_i [*6] |-> !active_o && !cmd_start_o)
    else $error("activity while deselected");
  chk_drive_active: assert property ($fell(sdo_oe_n_o) |-> active_o)
    else $error("output driven in standby");
  chk_start_valid: assert property (cmd_start_o |=> active_o && cmd_code_o inside {[8'h01:8'h06]})
    else $error("start without valid active command");
  chk_protect_frozen: assert property (!(wp_n_i || $past(wp_n_i) || $past(wp_n_i, 2) || $past(wp_n_i, 3))
    |=> $stable(protect_size_bit_hi_o) && $stable(protect_size_bit_lo_o))
    else $error("protect bits moved while write protected");
  chk_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte not held");
  cov_start: cover property (cmd_start_o);
  cov_drive: cover property ($fell(sdo_oe_n_o));
  cov_drop: cover property (rx_drop_o);
endmodule // sef_chk
bind sef_front_end sef_chk u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i),
  .pause_n_i(pause_n_i), .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_drop_o(rx_drop_o), .cmd_start_o(cmd_start_o),
  .cmd_code_o(cmd_code_o), .active_o(active_o), .protect_size_bit_hi_o(protect_size_bit_hi_o),
  .protect_size_bit_lo_o(protect_size_bit_lo_o));
`default_nettype wire

// >>> tb/sef_master.sv
// spi bus master model: select, clock and serial data toward the front end
`timescale 1ns/1ps
`default_nettype none
module sef_master (
  input  wire logic clk_sys_i,
  input  wire logic sdo_line_i,
  output var  logic sel_n_o,
  output var  logic sclk_o,
  output var  logic sdi_o
);
  logic cpol = 1'b0;
  // select starts low so the power-up case sees no falling edge
  initial begin
    sel_n_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // half of the 200 ns link period, changes land on falling clk edges
  task automatic half();
    repeat (4) @(negedge clk_sys_i);
  endtask
  // clock rests at its idle level, then select falls
  task automatic open_frame();
    sclk_o = cpol;
    half();
    sel_n_o = 1'b0;
    half();
  endtask
  // one byte each way, msb first; line read just before the rising edge
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = tx[i];
      half();
      rx[i] = sdo_line_i;
      sclk_o = 1'b1;
      half();
    end
  endtask
  // clock pulses with data moving, for the pause case
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      sdi_o = ~sdi_o;
      half();
      sclk_o = 1'b0;
      half();
    end
  endtask
  // released data line shows the inverse of its last value, not a stale bit
  task automatic close_frame();
    sclk_o = cpol;
    half();
    sel_n_o = 1'b1;
    sdi_o = ~sdi_o;
    half();
  endtask
endmodule // sef_master
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the serial memory front end
`include "sef_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       pause_n_i = 1'b1;
  logic       wp_n_i = 1'b1;
  logic       rx_ready_i = 1'b1;
  logic [7:0] tx_data_i = 8'hC3;
  logic       sel_n, sclk, sdi, sdo_o, sdo_oe_n_o, tx_next_o, rx_valid_o, rx_full_o, rx_drop_o;
  logic       cmd_start_o, active_o, p_hi, p_lo;
  logic [7:0] rx_data_o, cmd_code_o, rb;
  logic [7:0] got_q[$];
  int         n_errors = 0, n_compared = 0, n_starts = 0, n_drops = 0;
  wire        sdo_line;
  assign sdo_line = sdo_oe_n_o ? 1'bz : sdo_o;
  always #12.5 clk_sys_i = ~clk_sys_i;
  sef_front_end u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sel_n_i(sel_n), .sclk_i(sclk), .sdi_i(sdi),
    .pause_n_i(pause_n_i), .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .tx_data_i(tx_data_i),
    .tx_next_o(tx_next_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_full_o(rx_full_o), .rx_drop_o(rx_drop_o), .cmd_start_o(cmd_start_o), .cmd_code_o(cmd_code_o),
    .active_o(active_o), .protect_size_bit_hi_o(p_hi), .protect_size_bit_lo_o(p_lo));
  sef_master u_master (.clk_sys_i(clk_sys_i), .sdo_line_i(sdo_line), .sel_n_o(sel_n), .sclk_o(sclk),
    .sdi_o(sdi));
  // user side: collect bytes, count pulses, offer the next read byte
  always @(posedge clk_sys_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) got_q.push_back(rx_data_o);
    if (cmd_start_o === 1'b1) n_starts++;
    if (rx_drop_o === 1'b1) n_drops++;
  end
  always @(negedge clk_sys_i) if (tx_next_o === 1'b1) tx_data_i <= tx_data_i ^ 8'h99;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // whole frame: opcode plus one argument byte when n > 0; last answer left in rb
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n);
    u_master.open_frame();
    u_master.xbyte(op, rb);
    if (n > 0) u_master.xbyte(arg, rb);
    u_master.close_frame();
  endtask
  // select already low at reset release: nothing may be decoded
  task automatic s_powerup();
    u_master.xbyte(`SEF_OP_RDSR, rb);
    u_master.xbyte(8'h00, rb);
    check("early answer", rb, 8'hZZ);
    check("early starts", n_starts[7:0], 8'h00);
    u_master.close_frame();
  endtask
  task automatic s_modes();
    for (int m = 0; m < 2; m++) begin
      u_master.cpol = m[0];
      cmd(`SEF_OP_RDSR, 8'h00, 1);
      check("status", rb, 8'h00);
      check("opcode", cmd_code_o, `SEF_OP_RDSR);
    end
    u_master.cpol = 1'b0;
  endtask
  // ends with both protect bits set, status 0C
  task automatic s_protect();
    cmd(`SEF_OP_WREN, 8'h00, 0);
    cmd(`SEF_OP_RDSR, 8'h00, 1);
    check("latch", rb, 8'h02);
    cmd(`SEF_OP_WRSR, 8'h0C, 1);
    check("bits set", {6'h00, p_hi, p_lo}, 8'h03);
    wp_n_i = 1'b0;
    cmd(`SEF_OP_WREN, 8'h00, 0);
    cmd(`SEF_OP_WRSR, 8'h00, 1);
    check("frozen", {6'h00, p_hi, p_lo}, 8'h03);
    wp_n_i = 1'b1;
    cmd(`SEF_OP_WRDI, 8'h00, 0);
    cmd(`SEF_OP_WRSR, 8'h00, 1);
    cmd(`SEF_OP_RDSR, 8'h00, 1);
    check("after disable", rb, 8'h0C);
  endtask
  // clock pulses during pause would rotate the 0C status if counted
  task automatic s_pause();
    u_master.open_frame();
    u_master.xbyte(`SEF_OP_RDSR, rb);
    // clock low first: the fall that launches the msb comes before the pause
    u_master.sclk_o = 1'b0;
    u_master.half();
    pause_n_i = 1'b0;
    u_master.pulses(3);
    check("paused hiz", {7'h00, sdo_oe_n_o}, 8'h01);
    check("still selected", {7'h00, active_o}, 8'h01);
    pause_n_i = 1'b1;
    u_master.half();
    u_master.xbyte(8'h00, rb);
    check("resumed", rb, 8'h0C);
    u_master.close_frame();
  endtask
  task automatic s_invalid();
    u_master.open_frame();
    u_master.xbyte(8'hA5, rb);
    u_master.half();
    check("standby", {7'h00, active_o}, 8'h00);
    u_master.xbyte(8'h00, rb);
    check("bad answer", rb, 8'hZZ);
    u_master.close_frame();
    cmd(`SEF_OP_RDSR, 8'h00, 1);
    check("restart", rb, 8'h0C);
  endtask
  task automatic s_read();
    got_q.delete();
    tx_data_i = 8'hC3;
    u_master.open_frame();
    u_master.xbyte(`SEF_OP_READ, rb);
    for (int i = 0; i < 3; i++) u_master.xbyte(8'h12 + 8'h22 * i[7:0], rb);
    u_master.xbyte(8'h00, rb);
    check("read 0", rb, 8'hC3);
    u_master.xbyte(8'h00, rb);
    check("read 1", rb, 8'h5A);
    u_master.close_frame();
    // the two dummy clocking bytes of the read reach the fifo as well
    check("addr count", got_q.size(), 8'h05);
    for (int i = 0; i < 3; i++) check("addr", got_q[i], 8'h12 + 8'h22 * i[7:0]);
  endtask
  // stalled consumer: 19 bytes into 16 places plus the output slot, then drain
  task automatic s_fifo();
    rx_ready_i = 1'b0;
    got_q.delete();
    n_drops = 0;
    u_master.open_frame();
    u_master.xbyte(`SEF_OP_WRITE, rb);
    for (int i = 0; i < 19; i++) u_master.xbyte(i[7:0], rb);
    u_master.close_frame();
    check("full", {7'h00, rx_full_o}, 8'h01);
    check("dropped", {7'h00, n_drops > 0}, 8'h01);
    rx_ready_i = 1'b1;
    for (int k = 0; k < 100 && got_q.size() < 17; k++) @(negedge clk_sys_i);
    repeat (8) @(negedge clk_sys_i);
    check("drained", got_q.size(), 8'h11);
    check("last kept", got_q[16], 8'h10);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    s_powerup();
    s_modes();
    s_protect();
    s_pause();
    s_invalid();
    s_read();
    s_fifo();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
